// File: hw/ifeb_regs.vh
`ifndef IFEB_REGS_VH
`define IFEB_REGS_VH
// Register indices on the core's special-register port
`define IFEB_ADDR_EDGE      3'h0
`define IFEB_ADDR_PC0       3'h1
`define IFEB_ADDR_PC1       3'h2
`define IFEB_ADDR_PC2       3'h3
`define IFEB_ADDR_PC3       3'h4
`define IFEB_ADDR_GT0       3'h5
`define IFEB_ADDR_GT1       3'h6
`define IFEB_ADDR_GM        3'h7
// Implemented-bit masks
`define IFEB_MASK_EDGE      8'h0f
`define IFEB_MASK_PC0       8'h7f
`define IFEB_MASK_PC1       8'h77
`define IFEB_MASK_PC2       8'hff
`define IFEB_MASK_PC3       8'h11
`define IFEB_MASK_GT0       8'hff
`define IFEB_MASK_GT1       8'hff
`define IFEB_MASK_GM        8'h33
// Field positions
`define IFEB_EDGE_PIN1_HI   3
`define IFEB_EDGE_PIN1_LO   2
`define IFEB_EDGE_PIN0_HI   1
`define IFEB_EDGE_PIN0_LO   0
`define IFEB_PC0_GIE        0
`define IFEB_PC0_PIN0_EN    1
`define IFEB_PC0_PIN1_EN    2
`define IFEB_PC0_ADC_EN     3
`define IFEB_PC0_PIN0_FLAG  4
`define IFEB_PC0_PIN1_FLAG  5
`define IFEB_PC0_ADC_FLAG   6
// Edge codes
`define IFEB_EDGE_OFF       2'h0
`define IFEB_EDGE_RISE      2'h1
`define IFEB_EDGE_FALL      2'h2
`define IFEB_EDGE_BOTH      2'h3
// Reset values
`define IFEB_RESET_VALUE    8'h00
// Request vector bit numbers
`define IFEB_REQ_PIN0       0
`define IFEB_REQ_PIN1       1
`define IFEB_REQ_ADC        2
`define IFEB_REQ_GRP0       3
`define IFEB_REQ_GRP1       4
`define IFEB_REQ_GRP2       5
`define IFEB_REQ_TB0        6
`define IFEB_REQ_TB1        7
`define IFEB_REQ_UART       8
`define IFEB_REQ_SERIAL     9
`define IFEB_REQ_SPI        10
`define IFEB_REQ_WIDTH      11
`endif

// File: hw/ifeb_pin_edge.v
`timescale 1ns/10ps
`include "ifeb_regs.vh"

module ifeb_pin_edge (
    input  wire       clk_in,
    input  wire       rstn_in,
    input  wire       pin_in,
    input  wire [1:0] mode_in,
    output reg        event_out
);

// ----------------------------------------
// Two-stage synchroniser and edge detect
// ----------------------------------------
reg sync_a;
reg sync_b;
reg sync_prev;

always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
        sync_a    <= 1'b0;
        sync_b    <= 1'b0;
        sync_prev <= 1'b0;
    end else begin
        sync_a    <= pin_in;
        sync_b    <= sync_a;
        sync_prev <= sync_b;
    end
end

always @* begin
    case (mode_in)
        `IFEB_EDGE_OFF:  event_out = 1'b0;
        `IFEB_EDGE_RISE: event_out = sync_b & ~sync_prev;
        `IFEB_EDGE_FALL: event_out = ~sync_b & sync_prev;
        `IFEB_EDGE_BOTH: event_out = sync_b ^ sync_prev;
        default:         event_out = 1'b0;
    endcase
end

endmodule

// File: hw/ifeb_interrupt_flag_enable_bank.v
`timescale 1ns/10ps
`include "ifeb_regs.vh"

// Operation
// - Edge bits 3:2 select pin 1 edge
// - Edge bits 1:0 select pin 0 edge
// - Bit 0 global enable gates all requests
// - Pin flags at bits 4 and 5
// - Enables: ADC bit3, pin1 bit2, pin0 bit1
// - ADC flag bit 6, bit 7 absent
// - Group flags 6:4, group enables 2:0
// - Serial, UART, timebase flags and enables
// - Only SPI flag bit4 and enable bit0
// - Timer group 0 flags 7:4, enables 3:0
// - Timer group 1 flags 7:4, enables 3:0
// - Unimplemented bits read zero, ignore writes
// - EEPROM/low-voltage flags 5:4, enables 1:0
// - Service clears global enable; flags still record
// - Group service clears group flag and global enable, not source flags; the set wins, so group flag stays set while a group source flag and its enable stay set
// - Pin service clears that pin flag
module ifeb_interrupt_flag_enable_bank (
    input  wire        clk_in,
    input  wire        rstn_in,
    input  wire [2:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire [7:0]  reg_wdata_in,
    output reg  [7:0]  reg_rdata_out,
    input  wire        pin0_in,
    input  wire        pin1_in,
    input  wire        adc_event_in,
    input  wire        timebase0_event_in,
    input  wire        timebase1_event_in,
    input  wire        uart_event_in,
    input  wire        serial_if_event_in,
    input  wire        spi_event_in,
    input  wire [3:0]  timer_grp0_event_in,
    input  wire [3:0]  timer_grp1_event_in,
    input  wire        eeprom_done_event_in,
    input  wire        low_voltage_event_in,
    input  wire        service_in,
    input  wire [3:0]  service_id_in,
    output wire [10:0] irq_request_out,
    output wire        irq_pending_out
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] external_edge_select;
reg [7:0] primary_control_0;
reg [7:0] primary_control_1;
reg [7:0] primary_control_2;
reg [7:0] primary_control_3;
reg [7:0] grouped_timer_control_0;
reg [7:0] grouped_timer_control_1;
reg [7:0] grouped_misc_control;

reg [7:0] next_primary_control_0;
reg [7:0] next_primary_control_1;
reg [7:0] next_primary_control_2;
reg [7:0] next_primary_control_3;
reg [7:0] next_grouped_timer_control_0;
reg [7:0] next_grouped_timer_control_1;
reg [7:0] next_grouped_misc_control;

wire pin0_event;
wire pin1_event;

// Merge a register write, hardware set pulses and a hardware clear
function [7:0] merge;
    input [7:0] cur;
    input       wr;
    input [7:0] wdata;
    input [7:0] mask;
    input [7:0] set_bits;
    input [7:0] clr_bits;
    reg   [7:0] v;
    begin
        v     = wr ? wdata : cur;
        v     = v & ~clr_bits;
        v     = v | set_bits;
        merge = v & mask;
    end
endfunction

// Any source flag whose enable is also set, in a flag-high/enable-low layout
function any_armed;
    input [7:0] r;
    begin
        any_armed = |(r[7:4] & r[3:0]);
    end
endfunction

function wr_hit;
    input [2:0] addr;
    input [2:0] idx;
    input       wr;
    begin
        wr_hit = wr && (addr == idx);
    end
endfunction

// ----------------------------------------
// External pin edge detection
// ----------------------------------------
ifeb_pin_edge u_pin0 (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    (pin0_in),
    .mode_in   (external_edge_select[`IFEB_EDGE_PIN0_HI:`IFEB_EDGE_PIN0_LO]),
    .event_out (pin0_event)
);

ifeb_pin_edge u_pin1 (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    (pin1_in),
    .mode_in   (external_edge_select[`IFEB_EDGE_PIN1_HI:`IFEB_EDGE_PIN1_LO]),
    .event_out (pin1_event)
);

// ----------------------------------------
// Service decode
// ----------------------------------------
wire svc_pin0 = service_in && (service_id_in == 4'd`IFEB_REQ_PIN0);
wire svc_pin1 = service_in && (service_id_in == 4'd`IFEB_REQ_PIN1);
wire svc_adc  = service_in && (service_id_in == 4'd`IFEB_REQ_ADC);
wire svc_grp0 = service_in && (service_id_in == 4'd`IFEB_REQ_GRP0);
wire svc_grp1 = service_in && (service_id_in == 4'd`IFEB_REQ_GRP1);
wire svc_grp2 = service_in && (service_id_in == 4'd`IFEB_REQ_GRP2);

// Group aggregates from the enabled source flags
wire grp0_armed = any_armed(grouped_timer_control_0);
wire grp1_armed = any_armed(grouped_timer_control_1);
wire grp2_armed = any_armed({2'h0, grouped_misc_control[5:4],
                             2'h0, grouped_misc_control[1:0]});

// ----------------------------------------
// Next-state logic
// ----------------------------------------
always @* begin
    // Global enable cleared on any service; set pulses still recorded
    next_primary_control_0 = merge(primary_control_0,
        wr_hit(reg_addr_in, `IFEB_ADDR_PC0, reg_wr_in), reg_wdata_in,
        `IFEB_MASK_PC0,
        {1'b0, adc_event_in, pin1_event, pin0_event, 4'h0},
        {1'b0, svc_adc, svc_pin1, svc_pin0, 3'h0, service_in});

    next_primary_control_1 = merge(primary_control_1,
        wr_hit(reg_addr_in, `IFEB_ADDR_PC1, reg_wr_in), reg_wdata_in,
        `IFEB_MASK_PC1,
        {1'b0, grp2_armed, grp1_armed, grp0_armed, 4'h0},
        {1'b0, svc_grp2, svc_grp1, svc_grp0, 4'h0});

    next_primary_control_2 = merge(primary_control_2,
        wr_hit(reg_addr_in, `IFEB_ADDR_PC2, reg_wr_in), reg_wdata_in,
        `IFEB_MASK_PC2,
        {serial_if_event_in, uart_event_in, timebase1_event_in,
         timebase0_event_in, 4'h0},
        8'h00);

    next_primary_control_3 = merge(primary_control_3,
        wr_hit(reg_addr_in, `IFEB_ADDR_PC3, reg_wr_in), reg_wdata_in,
        `IFEB_MASK_PC3,
        {3'h0, spi_event_in, 4'h0}, 8'h00);

    // Source flags in groups are left for software to clear
    next_grouped_timer_control_0 = merge(grouped_timer_control_0,
        wr_hit(reg_addr_in, `IFEB_ADDR_GT0, reg_wr_in), reg_wdata_in,
        `IFEB_MASK_GT0, {timer_grp0_event_in, 4'h0}, 8'h00);

    next_grouped_timer_control_1 = merge(grouped_timer_control_1,
        wr_hit(reg_addr_in, `IFEB_ADDR_GT1, reg_wr_in), reg_wdata_in,
        `IFEB_MASK_GT1, {timer_grp1_event_in, 4'h0}, 8'h00);

    next_grouped_misc_control = merge(grouped_misc_control,
        wr_hit(reg_addr_in, `IFEB_ADDR_GM, reg_wr_in), reg_wdata_in,
        `IFEB_MASK_GM,
        {2'h0, eeprom_done_event_in, low_voltage_event_in, 4'h0}, 8'h00);
end

// ----------------------------------------
// State update
// ----------------------------------------
always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
        external_edge_select    <= `IFEB_RESET_VALUE;
        primary_control_0       <= `IFEB_RESET_VALUE;
        primary_control_1       <= `IFEB_RESET_VALUE;
        primary_control_2       <= `IFEB_RESET_VALUE;
        primary_control_3       <= `IFEB_RESET_VALUE;
        grouped_timer_control_0 <= `IFEB_RESET_VALUE;
        grouped_timer_control_1 <= `IFEB_RESET_VALUE;
        grouped_misc_control    <= `IFEB_RESET_VALUE;
    end else begin
        if (wr_hit(reg_addr_in, `IFEB_ADDR_EDGE, reg_wr_in)) begin
            external_edge_select <= reg_wdata_in & `IFEB_MASK_EDGE;
        end
        primary_control_0       <= next_primary_control_0;
        primary_control_1       <= next_primary_control_1;
        primary_control_2       <= next_primary_control_2;
        primary_control_3       <= next_primary_control_3;
        grouped_timer_control_0 <= next_grouped_timer_control_0;
        grouped_timer_control_1 <= next_grouped_timer_control_1;
        grouped_misc_control    <= next_grouped_misc_control;
    end
end

// ----------------------------------------
// Read-back
// ----------------------------------------
always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
        reg_rdata_out <= `IFEB_RESET_VALUE;
    end else begin
        case (reg_addr_in)
            `IFEB_ADDR_EDGE: reg_rdata_out <= external_edge_select;
            `IFEB_ADDR_PC0:  reg_rdata_out <= primary_control_0;
            `IFEB_ADDR_PC1:  reg_rdata_out <= primary_control_1;
            `IFEB_ADDR_PC2:  reg_rdata_out <= primary_control_2;
            `IFEB_ADDR_PC3:  reg_rdata_out <= primary_control_3;
            `IFEB_ADDR_GT0:  reg_rdata_out <= grouped_timer_control_0;
            `IFEB_ADDR_GT1:  reg_rdata_out <= grouped_timer_control_1;
            `IFEB_ADDR_GM:   reg_rdata_out <= grouped_misc_control;
            default:         reg_rdata_out <= `IFEB_RESET_VALUE;
        endcase
    end
end

// ----------------------------------------
// Request presentation
// ----------------------------------------
wire gie = primary_control_0[`IFEB_PC0_GIE];

assign irq_request_out[`IFEB_REQ_PIN0] = gie & primary_control_0[`IFEB_PC0_PIN0_FLAG]
                                       & primary_control_0[`IFEB_PC0_PIN0_EN];
assign irq_request_out[`IFEB_REQ_PIN1] = gie & primary_control_0[`IFEB_PC0_PIN1_FLAG]
                                       & primary_control_0[`IFEB_PC0_PIN1_EN];
assign irq_request_out[`IFEB_REQ_ADC]  = gie & primary_control_0[`IFEB_PC0_ADC_FLAG]
                                       & primary_control_0[`IFEB_PC0_ADC_EN];
assign irq_request_out[`IFEB_REQ_GRP2:`IFEB_REQ_GRP0] =
    {3{gie}} & primary_control_1[6:4] & primary_control_1[2:0];
assign irq_request_out[`IFEB_REQ_SERIAL:`IFEB_REQ_TB0] =
    {4{gie}} & primary_control_2[7:4] & primary_control_2[3:0];
assign irq_request_out[`IFEB_REQ_SPI]  = gie & primary_control_3[4]
                                       & primary_control_3[0];
assign irq_pending_out = |irq_request_out;

endmodule

// File: testbench/ifeb_asserts.sv
`timescale 1ns/10ps
module ifeb_asserts (
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic [2:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        adc_event_in,
    input wire logic        service_in,
    input wire logic [10:0] irq_request_out,
    input wire logic        irq_pending_out
);
    localparam logic [63:0] MASKS = 64'h33ffff11ff777f0f;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // ----------------------------
    // Read path and request gating
    // ----------------------------
    sequence s_adc_seen;
        adc_event_in ##1 reg_addr_in == 3'h1;
    endsequence
    sequence s_edge_wr;
        reg_wr_in && reg_addr_in == 3'h0 ##1 reg_addr_in == 3'h0;
    endsequence
    a_gie_off_quiet: assert property (
        reg_wr_in && reg_addr_in == 3'h1 && !reg_wdata_in[0] |=> !irq_pending_out)
        else $error("request while global enable off");
    a_unimpl_zero: assert property (
        (reg_rdata_out & ~MASKS[$past(reg_addr_in) * 8 +: 8]) == 8'h00)
        else $error("unimplemented bit read as one");
    a_edge_write: assert property (
        s_edge_wr |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h0f))
        else $error("edge select read back wrong");
    a_adc_flag_set: assert property (
        s_adc_seen |=> reg_rdata_out[6])
        else $error("adc flag not set");
    a_service_blocks: assert property (
        service_in && !(reg_wr_in && reg_addr_in == 3'h1) |=> !irq_pending_out)
        else $error("request after service");
    a_pin_request: assert property (
        $past(reg_addr_in) == 3'h1 |-> $past(irq_request_out[1:0]) ==
        (reg_rdata_out[5:4] & reg_rdata_out[2:1] & {2{reg_rdata_out[0]}}))
        else $error("pin request mismatch");
    a_adc_request: assert property (
        $past(reg_addr_in) == 3'h1 |-> $past(irq_request_out[2]) ==
        (reg_rdata_out[6] & reg_rdata_out[3] & reg_rdata_out[0]))
        else $error("adc request mismatch");
    a_tb_request: assert property (
        $past(reg_addr_in) == 3'h3 && $past(irq_request_out[6]) |-> reg_rdata_out[4] &&
        reg_rdata_out[0])
        else $error("timebase request without flag");
endmodule

bind ifeb_interrupt_flag_enable_bank ifeb_asserts i_asserts (.clk_in, .rstn_in, .reg_addr_in,
    .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .adc_event_in, .service_in, .irq_request_out,
    .irq_pending_out);

// File: testbench/ifeb_event_source.sv
`timescale 1ns/10ps
module ifeb_event_source (
    input  wire logic        clk_in,
    input  wire logic [15:0] fire_in,
    output logic      [15:0] event_out
);
    // One-cycle set pulses of the peripherals
    always @(posedge clk_in) begin
        event_out <= fire_in;
    end
endmodule

// File: testbench/ifeb_interrupt_flag_enable_bank_tb_top.sv
`timescale 1ns/10ps
module ifeb_interrupt_flag_enable_bank_tb_top;
    localparam logic [63:0] MASKS = 64'h33ffff11ff777f0f;
    localparam logic [15:0] FV [10] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010,
        16'h0020, 16'h0040, 16'h0080, 16'h0800, 16'h1000};
    localparam logic [2:0]  FA [10] = '{3'h1, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h7, 3'h7,
        3'h5, 3'h6};
    localparam logic [7:0]  FX [10] = '{8'h40, 8'h10, 8'h20, 8'h40, 8'h80, 8'h10, 8'h20,
        8'h10, 8'h80, 8'h10};
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [2:0]  reg_addr_in = 3'h0;
    logic        reg_wr_in = 1'b0;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        pin0_in = 1'b0;
    logic        pin1_in = 1'b0;
    logic        service_in = 1'b0;
    logic [3:0]  service_id_in = 4'h0;
    logic [15:0] fire = 16'h0000;
    logic [7:0]  rd_val;
    wire  [15:0] ev;
    wire  [7:0]  reg_rdata_out;
    wire  [10:0] irq_request_out;
    wire         irq_pending_out;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #2 clk_in = ~clk_in;
    ifeb_event_source i_src (.clk_in, .fire_in(fire), .event_out(ev));
    ifeb_interrupt_flag_enable_bank i_dut (.clk_in, .rstn_in, .reg_addr_in, .reg_wr_in,
        .reg_wdata_in, .reg_rdata_out, .pin0_in, .pin1_in, .adc_event_in(ev[0]),
        .timebase0_event_in(ev[1]), .timebase1_event_in(ev[2]), .uart_event_in(ev[3]),
        .serial_if_event_in(ev[4]), .spi_event_in(ev[5]), .eeprom_done_event_in(ev[6]),
        .low_voltage_event_in(ev[7]), .timer_grp0_event_in(ev[11:8]),
        .timer_grp1_event_in(ev[15:12]), .service_in, .service_id_in, .irq_request_out,
        .irq_pending_out);

    task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge clk_in);
        #1 reg_wr_in = 1'b0;
        @(posedge clk_in);
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        reg_addr_in = a;
        @(posedge clk_in);
        #1 rd_val = reg_rdata_out;
    endtask
    task automatic svc(input logic [3:0] id);
        service_id_in = id;
        service_in = 1'b1;
        @(posedge clk_in);
        #1 service_in = 1'b0;
    endtask
    task automatic pulse(input logic [15:0] v, input logic [2:0] a);
        reg_addr_in = a;
        fire = v;
        @(posedge clk_in);
        #1 fire = 16'h0000;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // -----
    // Tests
    // -----
    initial begin
        repeat (5) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0]);
            chk("reset value", rd_val, 8'h00);
            wr(a[2:0], 8'hff);
            rd(a[2:0]);
            chk("ones read", rd_val, MASKS[a * 8 +: 8]);
        end
        chk("all requests", irq_request_out, 11'h7ff);
        for (int a = 7; a >= 0; a--) begin
            wr(a[2:0], 8'h00);
            rd(a[2:0]);
            chk("zeros read", rd_val, 8'h00);
        end
        $display("registers done");
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(3'h0, 8'(m << (2 * p)));
                for (int lv = 1; lv >= 0; lv--) begin
                    {pin1_in, pin0_in} = 2'(lv << p);
                    repeat (4) @(posedge clk_in);
                    #1;
                    rd(3'h1);
                    chk("pin flag", rd_val, 8'((lv ? m & 1 : m >> 1) << 4 + p));
                    wr(3'h1, 8'h00);
                end
            end
        end
        $display("edges done");
        for (int i = 0; i < 10; i++) begin
            pulse(FV[i], FA[i]);
            rd(FA[i]);
            chk("source flag", rd_val, FX[i]);
            wr(FA[i], 8'h00);
        end
        $display("sources done");
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h03);
        pin0_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        chk("pin request", irq_request_out, 11'h001);
        chk("pin pending", irq_pending_out, 1'b1);
        svc(4'h0);
        rd(3'h1);
        chk("pin serviced", rd_val, 8'h02);
        pulse(16'h0001, 3'h1);
        rd(3'h1);
        chk("masked flag", rd_val, 8'h42);
        chk("masked pending", irq_pending_out, 1'b0);
        pin0_in = 1'b0;
        wr(3'h1, 8'h00);
        $display("service done");
        wr(3'h7, 8'h02);
        wr(3'h2, 8'h04);
        wr(3'h1, 8'h01);
        pulse(16'h0040, 3'h7);
        rd(3'h2);
        chk("group flag", rd_val, 8'h44);
        chk("group request", irq_request_out, 11'h020);
        svc(4'h5);
        rd(3'h7);
        chk("source kept", rd_val, 8'h22);
        rd(3'h1);
        chk("global cleared", rd_val, 8'h00);
        wr(3'h7, 8'h02);
        wr(3'h2, 8'h04);
        rd(3'h2);
        chk("group idle", rd_val, 8'h04);
        $display("group done");
        wr(3'h1, 8'h7f);
        chk("pc0 requests", irq_request_out, 11'h007);
        svc(4'h1);
        rd(3'h1);
        chk("pin1 serviced", rd_val, 8'h5e);
        svc(4'h2);
        rd(3'h1);
        chk("adc serviced", rd_val, 8'h1e);
        wr(3'h2, 8'h77);
        svc(4'h3);
        rd(3'h2);
        chk("group0 serviced", rd_val, 8'h67);
        svc(4'h4);
        rd(3'h2);
        chk("group1 serviced", rd_val, 8'h47);
        $display("service ids done");
        complete_run();
    end
endmodule
